// ===== common/tmcc_params.svh
// Register offsets, field positions, reset values and divider counts of the timer core
`ifndef TMCC_PARAMS_SVH
`define TMCC_PARAMS_SVH
`define TMCC_ADDR_W 8
`define TMCC_OFF_T0 8'h00
`define TMCC_OFF_T1 8'h10
`define TMCC_OFF_T2 8'h20
`define TMCC_OFF_CTRL0 2'h0
`define TMCC_OFF_CTRL1 2'h1
`define TMCC_OFF_COUNT 2'h2
`define TMCC_OFF_CCRA 2'h3
`define TMCC_OFF_STATUS 8'h30
`define TMCC_OFF_MASK 8'h34
`define TMCC_C0_PAUSE 7
`define TMCC_C0_CLKSEL 4
`define TMCC_C0_RUN 3
`define TMCC_C0_CCRP 0
`define TMCC_C1_MODE 6
`define TMCC_C1_EDGE 4
`define TMCC_C1_INIT 3
`define TMCC_C1_POL 2
`define TMCC_C1_DPX 1
`define TMCC_C1_CCLR 0
`define TMCC_RST_CTRL 8'h00
`define TMCC_RST_CCRA 10'h000
`define TMCC_RST_IRQ 6'h00
`define TMCC_DIV_SYS4 6'h03
`define TMCC_DIV_H16 6'h0F
`define TMCC_DIV_H64 6'h3F
`define TMCC_RESP_OKAY 2'h0
`define TMCC_RESP_SLVERR 2'h2
`endif

// ===== common/tmcc_pkg.sv
// Types and shared decode of the timer core
package tmcc_pkg;
   typedef enum logic [1:0] {
      TMCC_CMP_OUT,
      TMCC_CAPTURE,
      TMCC_PWM,
      TMCC_TIMER
   } tmcc_mode_t;

   // Capture edge decode: rise, fall, both, none
   function automatic logic tmccEdgeHit(input logic [1:0] sel, input logic rise,
                                        input logic fall);
      unique case (sel)
         2'h0: tmccEdgeHit = rise;
         2'h1: tmccEdgeHit = fall;
         2'h2: tmccEdgeHit = rise | fall;
         2'h3: tmccEdgeHit = 1'b0;
      endcase
   endfunction : tmccEdgeHit
endpackage : tmcc_pkg

// ===== design/tmcc_top.sv
// Three-timer core: two standard units, one periodic unit, AXI4-Lite registers
// Function
// - Each unit has an up counter compared against programmed comparator values.
// - Compare match raises interrupt; may clear counter and change output pin.
// - Two interrupt sources per unit: comparator A and comparator P.
// - Three-bit clock select: sys/4, sys, high/16, high/64, sub, external pin.
// - External pin edges advance the counter as time base or event counter.
// - External clock active edge selectable rising or falling.
// - Single pulse mode: external clock pin is the start trigger.
// - Capture input edge rising, falling or both via two-bit select.
// - Periodic unit also captures on its external clock pin.
// - Inverted output is always the inverse of the primary output.
// - Compare output mode: match drives output high, low or toggles.
// - PWM waveform appears on the same primary and inverted outputs.
// - Modes: timer, capture, compare output, single pulse, edge PWM.
// - Three units: two standard with indices, one periodic.
// - Second standard unit has no external clock; that select gives no ticks.
// - Run bit rising clears counter; falling holds residual value.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "tmcc_params.svh"

module tmcc_unit #(
   parameter int CNT_W = 10,
   parameter bit HAS_EXT_CLK = 1'b1,
   parameter bit HAS_EXT_CAP = 1'b0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [3:0] divTick,
   input wire logic subTick,
   input wire logic [7:0] ctrl0,
   input wire logic [7:0] ctrl1,
   input wire logic [CNT_W-1:0] ccra,
   input wire logic extClkPin,
   input wire logic capPin,
   output logic [CNT_W-1:0] count,
   output logic capStrobe,
   output logic matchA,
   output logic matchP,
   output logic primOut,
   output logic invOut
);
   import tmcc_pkg::*;

   logic [2:0] extSync_q;
   logic [2:0] capSync_q;
   logic extLvl_q;
   logic capLvl_q;
   logic extRise;
   logic extFall;
   logic capRise;
   logic capFall;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W:0] cntInc;
   logic run_q;
   logic spAct_q;
   logic spAct_d;
   logic outLvl_q;
   logic tick;
   logic runEdge;
   logic spMode;
   logic counting;
   logic aHit;
   logic pHit;
   logic clrHit;
   logic spStart;
   logic capEv;
   logic [CNT_W-1:0] pVal;
   logic [CNT_W-1:0] dutyVal;
   tmcc_mode_t mode;
   logic [2:0] clkSel;
   logic [1:0] edgeSel;

   assign mode = tmcc_mode_t'(ctrl1[`TMCC_C1_MODE +: 2]);
   assign clkSel = ctrl0[`TMCC_C0_CLKSEL +: 3];
   assign edgeSel = ctrl1[`TMCC_C1_EDGE +: 2];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         extSync_q <= 3'h0;
         capSync_q <= 3'h0;
      end else if (ce) begin
         extSync_q <= {extSync_q[1:0], extClkPin};
         capSync_q <= {capSync_q[1:0], capPin};
      end
   end

   // level accepted once stages two and three agree
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         extLvl_q <= 1'b0;
         capLvl_q <= 1'b0;
      end else if (ce) begin
         if (extSync_q[1] == extSync_q[2]) extLvl_q <= extSync_q[2];
         if (capSync_q[1] == capSync_q[2]) capLvl_q <= capSync_q[2];
      end
   end

   assign extRise = (extSync_q[1] == extSync_q[2]) && extSync_q[2] && !extLvl_q;
   assign extFall = (extSync_q[1] == extSync_q[2]) && !extSync_q[2] && extLvl_q;
   assign capRise = (capSync_q[1] == capSync_q[2]) && capSync_q[2] && !capLvl_q;
   assign capFall = (capSync_q[1] == capSync_q[2]) && !capSync_q[2] && capLvl_q;

   always_comb begin
      unique case (clkSel)
         3'h0: tick = divTick[0];
         3'h1: tick = divTick[1];
         3'h2: tick = divTick[2];
         3'h3: tick = divTick[3];
         3'h4, 3'h5: tick = subTick;
         3'h6: tick = HAS_EXT_CLK && extRise;
         // no external clock on this unit
         3'h7: tick = HAS_EXT_CLK && extFall;
      endcase
   end

   assign runEdge = ctrl0[`TMCC_C0_RUN] && !run_q;
   assign spMode = (mode == TMCC_PWM) && (edgeSel == 2'h3);
   assign counting = ctrl0[`TMCC_C0_RUN] && !ctrl0[`TMCC_C0_PAUSE] && tick
                     && (!spMode || spAct_q);
   assign cntInc = {1'b0, cnt_q} + {{CNT_W{1'b0}}, 1'b1};
   // Comparator P sees only the top three bits; zero means full wrap
   assign pVal = {ctrl0[`TMCC_C0_CCRP +: 3], {(CNT_W-3){1'b0}}};
   // compare against the value about to be reached
   assign aHit = counting && (cntInc[CNT_W-1:0] == ccra) && (mode != TMCC_CAPTURE);
   assign pHit = counting && (cntInc[CNT_W-1:0] == pVal);
   assign clrHit = (mode == TMCC_PWM) ? (ctrl1[`TMCC_C1_DPX] ? aHit : pHit)
                 : (ctrl1[`TMCC_C1_CCLR] ? aHit : pHit);
   // external clock pin starts a single pulse
   assign spStart = spMode && ctrl0[`TMCC_C0_RUN] && !spAct_q && (extRise || runEdge);
   // capture from pin, periodic unit also from clock pin
   assign capEv = ctrl0[`TMCC_C0_RUN] && (mode == TMCC_CAPTURE)
                  && (tmccEdgeHit(edgeSel, capRise, capFall)
                      || (HAS_EXT_CAP && tmccEdgeHit(edgeSel, extRise, extFall)));

   // restart on run rising, hold when stopped
   always_comb begin
      cnt_d = cnt_q;
      if (runEdge || spStart) cnt_d = '0;
      else if (counting) cnt_d = clrHit ? '0 : cntInc[CNT_W-1:0];
   end

   assign spAct_d = spStart ? 1'b1 : ((aHit || !ctrl0[`TMCC_C0_RUN]) ? 1'b0 : spAct_q);
   assign dutyVal = ctrl1[`TMCC_C1_DPX] ? pVal : ccra;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         spAct_q <= 1'b0;
      end else if (ce) begin
         cnt_q <= cnt_d;
         run_q <= ctrl0[`TMCC_C0_RUN];
         spAct_q <= spAct_d;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         outLvl_q <= 1'b0;
      end else if (ce) begin
         unique case (mode)
            TMCC_CMP_OUT: begin
               if (runEdge) outLvl_q <= ctrl1[`TMCC_C1_INIT];
               // low, high or toggle on A match
               else if (aHit) begin
                  unique case (edgeSel)
                     2'h0: outLvl_q <= outLvl_q;
                     2'h1: outLvl_q <= 1'b0;
                     2'h2: outLvl_q <= 1'b1;
                     2'h3: outLvl_q <= !outLvl_q;
                  endcase
               end
            end
            TMCC_PWM: begin
               // PWM high while count below duty
               if (edgeSel == 2'h2) outLvl_q <= ctrl0[`TMCC_C0_RUN] && (cnt_d < dutyVal);
               else if (spMode) outLvl_q <= spAct_d;
               else outLvl_q <= 1'b0;
            end
            TMCC_CAPTURE, TMCC_TIMER: outLvl_q <= outLvl_q;
         endcase
      end
   end

   assign count = cnt_q;
   assign capStrobe = capEv && ce;
   // separate A and P match events
   assign matchA = (aHit || capEv) && ce;
   assign matchP = pHit && ce;
   assign primOut = outLvl_q ^ ctrl1[`TMCC_C1_POL];
   assign invOut = !primOut;
endmodule : tmcc_unit

module tmcc_top #(
   parameter int CNT_W = 10
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic subTick,
   input wire logic [2:0] timerExtClockPin,
   input wire logic [2:0] timerCapturePin,
   output logic [2:0] timerPrimaryOut,
   output logic [2:0] timerInvertedOut,
   output logic irq,
   input wire logic [`TMCC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`TMCC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import tmcc_pkg::*;

   logic [7:0] ctrl0_q [3];
   logic [7:0] ctrl1_q [3];
   logic [CNT_W-1:0] ccra_q [3];
   logic [CNT_W-1:0] count [3];
   logic [2:0] capStrobe;
   logic [2:0] matchA;
   logic [2:0] matchP;
   logic [5:0] irqSts_q;
   logic [5:0] irqMask_q;
   logic [5:0] irqSet;
   logic [5:0] irqClr;
   logic [5:0] div_q;
   logic [3:0] divTick;
   logic [`TMCC_ADDR_W-1:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic awHeld_q;
   logic wHeld_q;
   logic doWrite;
   logic doRead;
   logic [31:0] rdVal;
   logic rdOk;
   logic wrOk;

   function automatic logic [1:0] regSel(input logic [`TMCC_ADDR_W-1:0] a);
      regSel = a[3:2];
   endfunction : regSel

   // Mapped when inside a timer window or on status/mask
   function automatic logic addrOk(input logic [`TMCC_ADDR_W-1:0] a);
      addrOk = (a[7:4] < 4'h3) || (a == `TMCC_OFF_STATUS) || (a == `TMCC_OFF_MASK);
   endfunction : addrOk

   function automatic logic [1:0] unitSel(input logic [`TMCC_ADDR_W-1:0] a);
      unitSel = a[5:4];
   endfunction : unitSel

   // Free-running prescaler shared by all units
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) div_q <= 6'h00;
      else if (ce) div_q <= div_q + 6'h01;
   end
   assign divTick = {div_q == `TMCC_DIV_H64, div_q[3:0] == 4'(`TMCC_DIV_H16), 1'b1,
                     div_q[1:0] == 2'(`TMCC_DIV_SYS4)};

   // two standard units and one periodic unit
   for (genvar i = 0; i < 3; i++) begin : g_unit
      tmcc_unit #(
         .CNT_W(CNT_W),
         .HAS_EXT_CLK(i != 1),
         .HAS_EXT_CAP(i == 2)
      ) u_unit (
         .clk(clk),
         .rstn(rstn),
         .ce(ce),
         .divTick(divTick),
         .subTick(subTick),
         .ctrl0(ctrl0_q[i]),
         .ctrl1(ctrl1_q[i]),
         .ccra(ccra_q[i]),
         .extClkPin(timerExtClockPin[i]),
         .capPin(timerCapturePin[i]),
         .count(count[i]),
         .capStrobe(capStrobe[i]),
         .matchA(matchA[i]),
         .matchP(matchP[i]),
         .primOut(timerPrimaryOut[i]),
         .invOut(timerInvertedOut[i])
      );
      assign irqSet[2*i] = matchA[i];
      assign irqSet[2*i+1] = matchP[i];
   end

   assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
   assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid && ce;
   assign wrOk = addrOk(awAddr_q);

   // Address and data may arrive in either order
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TMCC_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrOk ? `TMCC_RESP_OKAY : `TMCC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control registers; capture beats a same-cycle software write to CCRA
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 3; i++) begin
            ctrl0_q[i] <= `TMCC_RST_CTRL;
            ctrl1_q[i] <= `TMCC_RST_CTRL;
            ccra_q[i] <= `TMCC_RST_CCRA;
         end
         irqMask_q <= `TMCC_RST_IRQ;
      end else if (ce) begin
         for (int i = 0; i < 3; i++) begin
            if (doWrite && (awAddr_q[7:4] == 4'(i))) begin
               unique case (regSel(awAddr_q))
                  `TMCC_OFF_CTRL0: if (wStrb_q[0]) ctrl0_q[i] <= wData_q[7:0];
                  `TMCC_OFF_CTRL1: if (wStrb_q[0]) ctrl1_q[i] <= wData_q[7:0];
                  `TMCC_OFF_COUNT: ctrl0_q[i] <= ctrl0_q[i];
                  `TMCC_OFF_CCRA: begin
                     if (wStrb_q[0]) ccra_q[i][7:0] <= wData_q[7:0];
                     if (wStrb_q[1]) ccra_q[i][CNT_W-1:8] <= wData_q[CNT_W-1:8];
                  end
               endcase
            end
            if (capStrobe[i]) ccra_q[i] <= count[i];
         end
         if (doWrite && (awAddr_q == `TMCC_OFF_MASK) && wStrb_q[0]) irqMask_q <= wData_q[5:0];
      end
   end

   assign s_axi_arready = !s_axi_rvalid;
   assign doRead = s_axi_arvalid && s_axi_arready && ce;
   assign irqClr = (doRead && (s_axi_araddr == `TMCC_OFF_STATUS)) ? 6'h3F : 6'h00;

   // Read clears status; a new event in the same cycle survives
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) irqSts_q <= `TMCC_RST_IRQ;
      else if (ce) irqSts_q <= (irqSts_q & ~irqClr) | irqSet;
   end
   assign irq = |(irqSts_q & irqMask_q);

   always_comb begin
      rdVal = 32'h0000_0000;
      rdOk = addrOk(s_axi_araddr);
      if (s_axi_araddr == `TMCC_OFF_STATUS) rdVal[5:0] = irqSts_q;
      else if (s_axi_araddr == `TMCC_OFF_MASK) rdVal[5:0] = irqMask_q;
      else if (rdOk) begin
         unique case (regSel(s_axi_araddr))
            `TMCC_OFF_CTRL0: rdVal[7:0] = ctrl0_q[unitSel(s_axi_araddr)];
            `TMCC_OFF_CTRL1: rdVal[7:0] = ctrl1_q[unitSel(s_axi_araddr)];
            `TMCC_OFF_COUNT: rdVal[CNT_W-1:0] = count[unitSel(s_axi_araddr)];
            `TMCC_OFF_CCRA: rdVal[CNT_W-1:0] = ccra_q[unitSel(s_axi_araddr)];
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `TMCC_RESP_OKAY;
      end else if (ce) begin
         if (doRead) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdVal;
            s_axi_rresp <= rdOk ? `TMCC_RESP_OKAY : `TMCC_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : tmcc_top

// ===== dv/tmcc_top_assertions.sv
// Concurrent checks on the timer core ports
`timescale 1ns/1ps
`include "tmcc_params.svh"

module tmcc_top_assertions #(
   parameter int CNT_W = 10
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic subTick,
   input wire logic [2:0] timerExtClockPin,
   input wire logic [2:0] timerCapturePin,
   input wire logic [2:0] timerPrimaryOut,
   input wire logic [2:0] timerInvertedOut,
   input wire logic irq,
   input wire logic [`TMCC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`TMCC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sequence s_wrTaken;
      ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rdTaken;
      ce && s_axi_arvalid && s_axi_arready;
   endsequence

   property p_wrAnswer;
      s_wrTaken |=> ##1 s_axi_bvalid;
   endproperty
   a_wrAnswer: assert property (p_wrAnswer) else $error("write answer late");
   property p_rdAnswer;
      s_rdTaken |=> s_axi_rvalid;
   endproperty
   a_rdAnswer: assert property (p_rdAnswer) else $error("read answer late");
   property p_bHold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bHold: assert property (p_bHold) else $error("write answer dropped");
   property p_rHold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rHold: assert property (p_rHold) else $error("read answer dropped");
   property p_rDone;
      ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_rDone: assert property (p_rDone) else $error("read answer repeated");
   // Only one write in flight at a time
   property p_awBlock;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_awBlock: assert property (p_awBlock) else $error("write taken while answering");
   property p_arBlock;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_arBlock: assert property (p_arBlock) else $error("read taken while answering");
   property p_invOut;
      timerInvertedOut == ~timerPrimaryOut;
   endproperty
   a_invOut: assert property (p_invOut) else $error("inverted out wrong");
   property p_freeze;
      !ce |=> $stable(timerPrimaryOut) && $stable(irq);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with ce low");
endmodule : tmcc_top_assertions

bind tmcc_top tmcc_top_assertions #(.CNT_W(CNT_W)) u_tmcc_top_assertions (.*);

// ===== dv/tmcc_pin_source.sv
// Behavioural source of the timer clock, trigger and capture pins
`timescale 1ns/1ps

module tmcc_pin_source (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] extFlip,
   input wire logic [2:0] capFlip,
   output logic [2:0] extPin,
   output logic [2:0] capPin
);
   // pins idle low
   // Quiet from reset so the bench can set the unit up before any edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         extPin <= 3'h0;
         capPin <= 3'h0;
      end else begin
         extPin <= extPin ^ extFlip;
         capPin <= capPin ^ capFlip;
      end
   end
endmodule : tmcc_pin_source

// ===== dv/tmcc_tb_top.sv
// Register-level bench of the timer core
`timescale 1ns/1ps
`include "tmcc_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("Error at %0t: got %h exp %h", $time, g, e); end end

module tmcc_tb_top;
   import tmcc_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic subTick = 1'b0;
   logic [2:0] extFlip = 3'h0;
   logic [2:0] capFlip = 3'h0;
   logic [2:0] extPin, capPin, primOut, invOut;
   logic irq, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rdat;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int i, hi;
   logic [7:0] b;

   tmcc_top u_tmcc_top (.clk(clk), .rstn(rstn), .ce(ce), .subTick(subTick),
      .timerExtClockPin(extPin), .timerCapturePin(capPin), .timerPrimaryOut(primOut),
      .timerInvertedOut(invOut), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   tmcc_pin_source u_tmcc_pin_source (.clk(clk), .rstn(rstn), .extFlip(extFlip),
      .capFlip(capFlip), .extPin(extPin), .capPin(capPin));

   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) subTick <= ~subTick;

   function automatic logic [7:0] ra(input logic [7:0] base, input logic [1:0] idx);
      return base | {4'h0, idx, 2'b00};
   endfunction : ra

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end

   // Handshakes judged at the falling edge, acted on after the rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aTk, wTk, bTk;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(negedge clk);
         aTk = awvalid && awready;
         wTk = wvalid && wready;
         bTk = bvalid;
         resp = bresp;
         @(posedge clk);
         if (aTk) awvalid <= 1'b0;
         if (wTk) wvalid <= 1'b0;
         if (bTk) begin
            bready <= 1'b0;
            break;
         end
      end
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic tk, dn;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(negedge clk);
         tk = arvalid && arready;
         dn = rvalid;
         rdat = rdata;
         resp = rresp;
         @(posedge clk);
         if (tk) arvalid <= 1'b0;
         if (dn) begin
            rready <= 1'b0;
            break;
         end
      end
   endtask : rd

   task automatic flip(input logic e, input int n);
      @(posedge clk);
      if (e) extFlip[n] <= 1'b1;
      else capFlip[n] <= 1'b1;
      @(posedge clk);
      extFlip <= 3'h0;
      capFlip <= 3'h0;
      // Room for the three-stage synchroniser
      repeat (6) @(posedge clk);
   endtask : flip

   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      rd(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0));
      `CHK(rdat, 32'h00000000)
      rd(`TMCC_OFF_MASK);
      `CHK(rdat, 32'h00000000)
      rd(8'h3C);
      `CHK(resp, `TMCC_RESP_SLVERR)
      `CHK(rdat, 32'h00000000)
      wr(8'h3C, 32'h00000001);
      `CHK(resp, `TMCC_RESP_SLVERR)
      `CHK(invOut, 3'h7)
      $display("reset test done");
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CCRA), 32'h000003FF);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL1), 32'h000000C0);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000018);
      repeat (30) @(posedge clk);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000010);
      rd(ra(`TMCC_OFF_T0, `TMCC_OFF_COUNT));
      `CHK(rdat > 32'h00000010, 1'b1)
      b = rdat[7:0];
      repeat (10) @(posedge clk);
      rd(ra(`TMCC_OFF_T0, `TMCC_OFF_COUNT));
      `CHK(rdat[7:0], b)
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000018);
      rd(ra(`TMCC_OFF_T0, `TMCC_OFF_COUNT));
      `CHK(rdat < 32'h00000008, 1'b1)
      $display("run test done");
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000010);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CCRA), 32'h0000000A);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL1), 32'h00000031);
      wr(`TMCC_OFF_MASK, 32'h00000001);
      rd(`TMCC_OFF_STATUS);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000018);
      for (i = 0; i < 100 && irq !== 1'b1; i++) @(negedge clk);
      `CHK(irq, 1'b1)
      `CHK(primOut[0], 1'b1)
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000010);
      rd(ra(`TMCC_OFF_T0, `TMCC_OFF_COUNT));
      `CHK(rdat < 32'h0000000A, 1'b1)
      rd(`TMCC_OFF_STATUS);
      `CHK(rdat[0], 1'b1)
      rd(`TMCC_OFF_STATUS);
      `CHK(rdat, 32'h00000000)
      `CHK(irq, 1'b0)
      wr(`TMCC_OFF_MASK, 32'h00000000);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL1), 32'h00000030);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000019);
      repeat (140) @(posedge clk);
      `CHK(irq, 1'b0)
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000011);
      rd(`TMCC_OFF_STATUS);
      `CHK(rdat[1:0], 2'b11)
      $display("match test done");
      for (i = 0; i < 3; i++) begin
         b = (i == 0) ? `TMCC_OFF_T0 : ((i == 1) ? `TMCC_OFF_T1 : `TMCC_OFF_T2);
         wr(ra(b, `TMCC_OFF_CCRA), 32'h000003FF);
         wr(ra(b, `TMCC_OFF_CTRL1), 32'h000000C0);
         // Unit 0 on rising edges, units 1 and 2 on falling edges
         wr(ra(b, `TMCC_OFF_CTRL0), (i == 0) ? 32'h00000060 : 32'h00000070);
         wr(ra(b, `TMCC_OFF_CTRL0), (i == 0) ? 32'h00000068 : 32'h00000078);
         repeat (10) flip(1'b1, i);
         rd(ra(b, `TMCC_OFF_COUNT));
         `CHK(rdat, (i != 1) ? 32'h00000005 : 32'h00000000)
      end
      // Divide-by-64 source over about 260 cycles
      wr(ra(`TMCC_OFF_T1, `TMCC_OFF_CTRL0), 32'h00000038);
      repeat (256) @(posedge clk);
      wr(ra(`TMCC_OFF_T1, `TMCC_OFF_CTRL0), 32'h00000030);
      rd(ra(`TMCC_OFF_T1, `TMCC_OFF_COUNT));
      `CHK(rdat >= 32'h00000004 && rdat <= 32'h00000005, 1'b1)
      $display("external clock test done");
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000018);
      for (i = 0; i < 4; i++) begin
         wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL1), 32'h00000040 | (i << 4));
         rd(`TMCC_OFF_STATUS);
         flip(1'b0, 0);
         rd(`TMCC_OFF_STATUS);
         `CHK(rdat[0], (i == 0 || i == 2))
         flip(1'b0, 0);
         rd(`TMCC_OFF_STATUS);
         `CHK(rdat[0], (i == 1 || i == 2))
      end
      wr(ra(`TMCC_OFF_T2, `TMCC_OFF_CTRL1), 32'h00000040);
      wr(ra(`TMCC_OFF_T2, `TMCC_OFF_CTRL0), 32'h00000018);
      rd(`TMCC_OFF_STATUS);
      flip(1'b1, 2);
      rd(`TMCC_OFF_STATUS);
      `CHK(rdat[4], 1'b1)
      $display("capture test done");
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000010);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CCRA), 32'h00000020);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL1), 32'h000000A0);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000019);
      repeat (300) @(posedge clk);
      hi = 0;
      for (i = 0; i < 256; i++) begin
         @(negedge clk);
         if (primOut[0] === 1'b1) hi++;
      end
      `CHK(hi, 64)
      // Single pulse: run rise fires one pulse, then the pin retriggers
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000010);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL1), 32'h000000B0);
      wr(ra(`TMCC_OFF_T0, `TMCC_OFF_CTRL0), 32'h00000018);
      repeat (40) @(posedge clk);
      `CHK(primOut[0], 1'b0)
      flip(1'b1, 0);
      `CHK(primOut[0], 1'b1)
      @(posedge clk);
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      $display("pwm test done");
      final_report();
   end
endmodule : tmcc_tb_top
